/* File: hdl/asr_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// RULE_01: Memory is 256K words, 16 bits, two lanes.
// RULE_02: Chip select high tri-states both lanes.
// RULE_03: Read drives only lanes with select low.
// RULE_04: Write stores only lanes with select low.
// RULE_05: Selected with OE, WE high: bus floats.
// RULE_06: Write while select and WE both low.
// RULE_07: Data stable before terminating rising edge.
// RULE_08: Wait 100 us before first access.
// RULE_09: Read data valid after address access time.
// RULE_10: Old data held 3 ns after address.
// RULE_11: Read data valid 5 ns after OE.
// RULE_12: Address valid 7 ns before write end.
// RULE_13: Lane selects low 7 ns before end.
// RULE_14: OE-low write lasts turn-off plus setup.
// RULE_15: Joint select/WE rise keeps bus floating.
// RULE_16: Host never drives while device drives.
// RULE_17: Count all durations in clock periods.
module asr_ctrl
  #(
    parameter int POWERUP_CYCLES = asr_pkg::POWERUP_CYC
  )
  (
    // Clock and reset.
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst,
    // User request side.
    input  wire logic                     i_req_valid,
    output logic                          o_req_ready,
    input  wire asr_pkg::asr_req_t        i_req,
    output logic                          o_rd_valid,
    output logic [asr_pkg::DATA_W-1:0]    o_rd_data,
    output logic                          o_init_done,
    // Memory pins.
    output asr_pkg::asr_pins_t            o_pins,
    input  wire logic [asr_pkg::DATA_W-1:0] i_dq,
    output logic [asr_pkg::DATA_W-1:0]    o_dq,
    output logic [asr_pkg::DATA_W-1:0]    o_dq_oe_n
  );
  import asr_pkg::*;

  typedef enum logic [2:0] {ST_POWER, ST_IDLE, ST_READ, ST_TURN, ST_WRITE} asr_state_t;

  asr_state_t          state_r, state_nxt;
  logic [31:0]         pwr_cnt_r, pwr_cnt_nxt;
  logic [CNT_W-1:0]    cnt_r, cnt_nxt;
  asr_pins_t           pins_r, pins_nxt;
  logic [DATA_W-1:0]   dq_r, dq_nxt;
  logic [DATA_W-1:0]   dq_oe_n_r, dq_oe_n_nxt;
  logic [DATA_W-1:0]   rd_data_r, rd_data_nxt;
  logic [1:0]          lane_r, lane_nxt;
  logic                rd_valid_r, rd_valid_nxt;
  logic [DATA_W-1:0]   dq_s1_r, dq_s2_r, dq_s3_r;
  logic [DATA_W-1:0]   dq_filt_r, dq_filt_nxt;

  // Idle pin state: deselected, all strobes high, so the device floats.
  localparam asr_pins_t PINS_IDLE = '{addr: '0, chip_sel_n: 1'b1, out_en_n: 1'b1,
                                      wr_en_n: 1'b1, lower_lane_select_n: 1'b1,
                                      upper_lane_select_n: 1'b1};

  // Read data arrives from another timing domain, so it passes three flops.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dq_s1_r   <= '0;
      dq_s2_r   <= '0;
      dq_s3_r   <= '0;
      dq_filt_r <= '0;
    end
    else
    begin
      dq_s1_r   <= i_dq;
      dq_s2_r   <= dq_s1_r;
      dq_s3_r   <= dq_s2_r;
      dq_filt_r <= dq_filt_nxt;
    end
  end

  // A read-back word counts only once the last two stages agree, so a word caught mid-change is never taken.
  always_comb
  begin
    dq_filt_nxt = dq_filt_r;
    if (dq_s2_r == dq_s3_r)
      dq_filt_nxt = dq_s3_r;
  end

  // Sequencer next state. Each access is a full fixed-length pulse.
  always_comb
  begin
    state_nxt    = state_r;
    pwr_cnt_nxt  = pwr_cnt_r;
    cnt_nxt      = cnt_r;
    pins_nxt     = pins_r;
    dq_nxt       = dq_r;
    dq_oe_n_nxt  = dq_oe_n_r;
    rd_data_nxt  = rd_data_r;
    lane_nxt     = lane_r;
    rd_valid_nxt = 1'b0;
    case (state_r)
      ST_POWER:
      begin
        // RULE_08: power-up wait
        if (pwr_cnt_r >= 32'(POWERUP_CYCLES - 1))
          state_nxt = ST_IDLE;
        else
          pwr_cnt_nxt = pwr_cnt_r + 32'h1;
      end
      ST_IDLE:
      begin
        pins_nxt    = PINS_IDLE;
        dq_oe_n_nxt = '1;
        if (i_req_valid)
        begin
          // RULE_12: address set up with select
          pins_nxt.addr                = i_req.addr;
          pins_nxt.chip_sel_n          = 1'b0;
          // RULE_13: lane selects held whole pulse
          pins_nxt.lower_lane_select_n = ~i_req.lane_en[0];
          pins_nxt.upper_lane_select_n = ~i_req.lane_en[1];
          lane_nxt                     = i_req.lane_en;
          cnt_nxt                      = '0;
          if (i_req.write)
          begin
            // RULE_16: OE kept high so the device stays off the bus
            pins_nxt.out_en_n = 1'b1;
            dq_nxt            = i_req.wdata;
            state_nxt         = ST_WRITE;
          end
          else
          begin
            // RULE_03: read with WE high, OE low
            pins_nxt.out_en_n = 1'b0;
            state_nxt         = ST_READ;
          end
        end
      end
      ST_READ:
      begin
        // RULE_09: wait address access time
        // RULE_11: OE access covered by same wait
        // RULE_17: time counted in clocks
        if (cnt_r >= CNT_W'(READ_CYC + 2))
        begin
          // Sample lanes through the synchroniser; disabled lanes read as zero.
          rd_data_nxt  = {(lane_r[1] ? dq_filt_r[15:8] : 8'h00), (lane_r[0] ? dq_filt_r[7:0] : 8'h00)};
          rd_valid_nxt = 1'b1;
          // RULE_10: deselect before address moves
          pins_nxt     = PINS_IDLE;
          pins_nxt.addr = pins_r.addr;
          cnt_nxt      = '0;
          state_nxt    = ST_TURN;
        end
        else
          cnt_nxt = cnt_r + CNT_W'(1);
      end
      ST_TURN:
      begin
        // RULE_16: let device outputs turn off
        if (cnt_r >= CNT_W'(TURN_CYC - 1))
          state_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r + CNT_W'(1);
      end
      ST_WRITE:
      begin
        // RULE_06: WE low with select low
        pins_nxt.wr_en_n = 1'b0;
        // RULE_04: drive only enabled lanes
        dq_oe_n_nxt = {{LANE_W{~lane_r[1]}}, {LANE_W{~lane_r[0]}}};
        // RULE_14: pulse covers turn-off plus setup
        // RULE_07: data stable before WE rises
        if (cnt_r >= CNT_W'(WRITE_CYC))
        begin
          // RULE_15: WE rises first, select a cycle later
          pins_nxt.wr_en_n = 1'b1;
          cnt_nxt          = '0;
          state_nxt        = ST_TURN;
        end
        else
          cnt_nxt = cnt_r + CNT_W'(1);
      end
      default:
        state_nxt = ST_POWER;
    endcase
    // RULE_02: leaving a write releases the bus together with select, one cycle after WE rises
    if (state_r == ST_TURN)
    begin
      pins_nxt.chip_sel_n          = 1'b1;
      pins_nxt.lower_lane_select_n = 1'b1;
      pins_nxt.upper_lane_select_n = 1'b1;
      dq_oe_n_nxt                  = '1;
    end
  end

  // Sequencer registers.
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r    <= ST_POWER;
      pwr_cnt_r  <= '0;
      cnt_r      <= '0;
      pins_r     <= PINS_IDLE;
      dq_r       <= '0;
      dq_oe_n_r  <= '1;
      rd_data_r  <= '0;
      lane_r     <= '0;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      pwr_cnt_r  <= pwr_cnt_nxt;
      cnt_r      <= cnt_nxt;
      pins_r     <= pins_nxt;
      dq_r       <= dq_nxt;
      dq_oe_n_r  <= dq_oe_n_nxt;
      rd_data_r  <= rd_data_nxt;
      lane_r     <= lane_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // Outputs; ready is combinational so a request is taken in the same cycle.
  assign o_req_ready = (state_r == ST_IDLE);
  assign o_init_done = (state_r != ST_POWER);
  assign o_rd_valid  = rd_valid_r;
  assign o_rd_data   = rd_data_r;
  assign o_pins      = pins_r;
  assign o_dq        = dq_r;
  assign o_dq_oe_n   = dq_oe_n_r;

endmodule // asr_ctrl

/* File: include/asr_pkg.sv */
package asr_pkg;

  // Memory geometry: 256K words of 16 bits, two byte lanes.
  localparam int ADDR_W      = 18;
  localparam int DATA_W      = 16;
  localparam int LANE_W      = 8;

  // Clock period of i_sys_clk in picoseconds (50 MHz).
  localparam int CLK_PS      = 20000;

  // Device timing figures in ns (fast grade) and us.
  localparam int POWERUP_US          = 100;
  localparam int ADDRESS_ACCESS_TIME = 10;
  localparam int OE_ACCESS_NS        = 5;
  localparam int WRITE_PULSE_NS      = 7;
  localparam int WRITE_DATA_SETUP    = 6;
  localparam int WRITE_TURNOFF_DELAY = 5;
  localparam int OE_TURNOFF_NS       = 5;

  // Minimum times round up to whole cycles, never below one.
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int POWERUP_CYC = (POWERUP_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int READ_CYC    = min_cycles(ADDRESS_ACCESS_TIME) + 1;
  localparam int WRITE_CYC   = min_cycles(WRITE_TURNOFF_DELAY + WRITE_DATA_SETUP);
  localparam int TURN_CYC    = min_cycles(OE_TURNOFF_NS);
  localparam int CNT_W       = 8;

  // User request bundle.
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lane_en;  // Bit 0 lower lane, bit 1 upper lane, active high.
  } asr_req_t;

  // Memory-side pins (outputs of the controller).
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              chip_sel_n;
    logic              out_en_n;
    logic              wr_en_n;
    logic              lower_lane_select_n;
    logic              upper_lane_select_n;
  } asr_pins_t;

endpackage

/* File: testbench/asr_ctrl_props.sv */
`timescale 1ns/1ps
module asr_ctrl_props
  (
    // Watched controller ports.
    input wire logic                       i_sys_clk,
    input wire logic                       i_rst,
    input wire logic                       i_req_valid,
    input wire logic                       o_req_ready,
    input wire asr_pkg::asr_req_t          i_req,
    input wire logic                       o_rd_valid,
    input wire logic                       o_init_done,
    input wire asr_pkg::asr_pins_t         o_pins,
    input wire logic [asr_pkg::DATA_W-1:0] o_dq,
    input wire logic [asr_pkg::DATA_W-1:0] o_dq_oe_n
  );
  import asr_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Bus ownership, strobe order and read latency.
  a_cs_release: assert property (o_pins.chip_sel_n |-> &o_dq_oe_n)
    else $error("bus driven while deselected");
  a_read_float: assert property (!o_pins.out_en_n |-> &o_dq_oe_n)
    else $error("bus driven during read");
  a_ready_init: assert property (o_req_ready |-> o_init_done)
    else $error("ready before power-up wait");
  a_we_in_cs: assert property (!o_pins.wr_en_n |-> !o_pins.chip_sel_n)
    else $error("write strobe outside select");
  a_we_first: assert property ($rose(o_pins.wr_en_n) |-> !o_pins.chip_sel_n ##1 o_pins.chip_sel_n)
    else $error("select not released after write strobe");
  a_we_pulse: assert property ($fell(o_pins.wr_en_n) |=> o_pins.wr_en_n)
    else $error("write pulse length wrong");
  a_oe_read: assert property ($fell(o_pins.out_en_n) |-> !o_pins.chip_sel_n && o_pins.wr_en_n)
    else $error("output enable without read setup");
  a_rd_lat: assert property (i_req_valid && o_req_ready && !i_req.write |-> ##[6:7] o_rd_valid)
    else $error("read data late");
  a_lane_drive: assert property (!o_pins.wr_en_n |-> o_dq_oe_n == {{8{o_pins.upper_lane_select_n}},
    {8{o_pins.lower_lane_select_n}}})
    else $error("driven lanes differ from selects");
  a_data_hold: assert property ($rose(o_pins.wr_en_n) |-> $stable(o_dq))
    else $error("write data moved at write end");
endmodule // asr_ctrl_props

/* File: testbench/asr_sram_model.sv */
`timescale 1ns/1ps
module asr_sram_model
  (
    // Pins from the controller and resolved bus level.
    input  wire asr_pkg::asr_pins_t         i_pins,
    input  wire logic [asr_pkg::DATA_W-1:0] i_host_dq,
    input  wire logic [asr_pkg::DATA_W-1:0] i_host_oe_n,
    output logic [asr_pkg::DATA_W-1:0]      o_bus
  );
  import asr_pkg::*;
  logic [DATA_W-1:0] mem [0:(1 << ADDR_W)-1];
  logic [DATA_W-1:0] word, bus_c, nw;
  logic [1:0]        drv;
  logic              wr_on;
  // Unwritten words read as zero.
  initial
  begin
    for (int i = 0; i < (1 << ADDR_W); i++)
      mem[i] = '0;
  end
  // lane drive, floats show the inverse word.
  always @*
  begin
    word = mem[i_pins.addr];
    drv = {2{!i_pins.chip_sel_n && !i_pins.out_en_n && i_pins.wr_en_n}}
      & ~{i_pins.upper_lane_select_n, i_pins.lower_lane_select_n};
    for (int i = 0; i < DATA_W; i++)
      bus_c[i] = !i_host_oe_n[i] ? i_host_dq[i] : (drv[i/8] ? word[i] : ~word[i]);
  end
  // Data settles only after the access time; old data stands until then.
  assign #(ADDRESS_ACCESS_TIME) o_bus = bus_c;
  // Store selected lanes when the write overlap ends.
  assign wr_on = !i_pins.chip_sel_n && !i_pins.wr_en_n;
  always @(negedge wr_on)
  begin
    nw = word;
    if (!i_pins.lower_lane_select_n) nw[7:0] = bus_c[7:0];
    if (!i_pins.upper_lane_select_n) nw[15:8] = bus_c[15:8];
    mem[i_pins.addr] = nw;
  end
endmodule // asr_sram_model

/* File: testbench/asr_ctrl_tb.sv */
`timescale 1ns/1ps
module asr_ctrl_tb;
  import asr_pkg::*;
  logic              i_sys_clk   = 1'b0;
  logic              i_rst       = 1'b1;
  logic              i_req_valid = 1'b0;
  asr_req_t          i_req       = '0;
  logic              o_req_ready, o_rd_valid, o_init_done;
  logic [DATA_W-1:0] o_rd_data, i_dq, o_dq, o_dq_oe_n, q;
  asr_pins_t         o_pins;
  int                n_mismatch  = 0;
  int                checks_done = 0;
  // Short power-up count keeps the run brief.
  asr_ctrl #(.POWERUP_CYCLES(10)) u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req(i_req), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_init_done(o_init_done), .o_pins(o_pins), .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n));
  asr_sram_model u_mem (.i_pins(o_pins), .i_host_dq(o_dq), .i_host_oe_n(o_dq_oe_n), .o_bus(i_dq));
  // Clock of 20 ns period.
  initial
  begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_up();
    n_mismatch++;
    $display("MISMATCH %0t wait timed out", $time);
    summarize();
  endtask
  // Request is held until taken, so a refused request is never lost.
  task automatic req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_req <= '{wr, a, d, ln};
    i_req_valid <= 1'b1;
    @(negedge i_sys_clk);
    while (o_req_ready !== 1'b1)
    begin
      @(negedge i_sys_clk);
      if (++n > 50) give_up();
    end
    @(posedge i_sys_clk);
    i_req_valid <= 1'b0;
    n = 0;
    while (!wr && o_rd_valid !== 1'b1)
    begin
      @(negedge i_sys_clk);
      if (++n > 50) give_up();
    end
    q = o_rd_data;
  endtask
  task automatic t_power();
    int n;
    n = 0;
    repeat (5) @(negedge i_sys_clk);
    chk(o_req_ready, 1'b0);
    while (o_init_done !== 1'b1)
    begin
      @(negedge i_sys_clk);
      if (++n > 20) give_up();
    end
    chk(16'(n >= 3), 16'h0001);
  endtask
  task automatic t_lanes();
    req(1'b1, 18'h0155a, 16'ha5c3, 2'b11);
    for (int ln = 1; ln < 4; ln++)
    begin
      req(1'b0, 18'h0155a, 16'h0000, 2'(ln));
      chk(q, {ln[1] ? 8'ha5 : 8'h00, ln[0] ? 8'hc3 : 8'h00});
    end
    req(1'b1, 18'h0155a, 16'h0f1e, 2'b01);
    req(1'b1, 18'h0155a, 16'h7700, 2'b10);
    req(1'b0, 18'h0155a, 16'h0000, 2'b11);
    chk(q, 16'h771e);
  endtask
  task automatic t_b2b();
    req(1'b1, 18'h3ffff, 16'hbeef, 2'b11);
    req(1'b1, 18'h00000, 16'h1234, 2'b11);
    req(1'b0, 18'h3ffff, 16'h0000, 2'b11);
    chk(q, 16'hbeef);
    req(1'b0, 18'h00000, 16'h0000, 2'b11);
    chk(q, 16'h1234);
  endtask
  // Reset for three cycles, then the scenarios.
  initial
  begin
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_power();
    t_lanes();
    t_b2b();
    summarize();
  end
endmodule // asr_ctrl_tb
bind asr_ctrl asr_ctrl_props u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(i_req_valid),
  .o_req_ready(o_req_ready), .i_req(i_req), .o_rd_valid(o_rd_valid), .o_init_done(o_init_done),
  .o_pins(o_pins), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n));
